// >>> hw/cxl_pkg.sv
// Package of constants and carrier types for the transceiver mode controller
`default_nettype none
package cxl_pkg;
  // ---------------------------------------------------------------------------
  // Register map of the controller (software side)
  // ---------------------------------------------------------------------------
  localparam logic [3:0] CXL_REG_CTRL = 4'h0;
  localparam logic [3:0] CXL_REG_STATUS = 4'h1;
  localparam logic [3:0] CXL_REG_TXDATA = 4'h2;
  localparam logic [3:0] CXL_REG_WAKECNT = 4'h3;
  // CTRL fields
  localparam int CXL_CTRL_STANDBY = 0;
  localparam int CXL_CTRL_LOOPBACK = 1;
  localparam int CXL_CTRL_AUTOWAKE = 2;
  localparam int CXL_CTRL_TXBIT = 3;
  localparam logic [7:0] CXL_CTRL_RESET = 8'h00;
  // STATUS fields
  localparam int CXL_ST_RXLEVEL = 0;
  localparam int CXL_ST_ACTIVITY = 1;
  localparam int CXL_ST_WOKEN = 2;
  localparam int CXL_ST_STANDBY = 3;
  localparam int CXL_ST_LOOPBACK = 4;
  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CXL_CLK_MHZ = 100;
  localparam int CXL_WAKE_NS = 1500;
  localparam int CXL_WAKE_CYC = (CXL_WAKE_NS * CXL_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] CXL_WAKE_CYC8 = 8'(CXL_WAKE_CYC);

  typedef enum {CXL_ACTIVE, CXL_STANDBY, CXL_WAKING} cxl_mode_t;

  // Pins towards the transceiver
  typedef struct packed {
    logic txd;
    logic modeSelect;
    logic loopbackSelect;
  } cxl_pins_t;
endpackage
`default_nettype wire

// >>> hw/cxl_sync.sv
// Two-stage synchroniser for the receive pin
`default_nettype none
module cxl_sync
  import cxl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic stage1;
  // ---------------------------------------------------------------------------
  // Synchroniser
  // ---------------------------------------------------------------------------
  // Recessive (high) is the safe idle level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b1;
      dout <= 1'b1;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule
`default_nettype wire

// >>> hw/cxl_ctrl.sv
// Host controller driving mode, loopback and transmit pins of a CAN transceiver
// Behaviour
// - Mode select low gives active mode
// - Mode select high gives standby
// - Watch dominant edge, drive mode low
// - Loopback select high blocks transmit
// - Baud search starts at 125 kbps (no search in hardware; software runs it through the CTRL loopback bit)
// - Judge rate from error/received status (no error status here; software judges the rate)
// - Repeat trials, then drive loopback low (loopback pin only follows the CTRL bit that software writes)
//
// Design decisions made here: the strobed register port and the register addresses.
`default_nettype none
module cxl_ctrl
  import cxl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [7:0] rdData,
  input wire logic protoTxd,
  output logic protoRxd,
  input wire logic rxdPin,
  output cxl_pins_t pins
);
  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [7:0] ctrl;
  logic rxSync;
  logic rxPrev;
  logic activity;
  logic woken;
  logic [7:0] wakeCnt;
  cxl_mode_t mode;
  cxl_mode_t next_mode;
  logic wrCtrl;
  logic clrStatus;
  logic dominantEdge;

  cxl_sync uSync (
    .clk(clk),
    .rst_n(rst_n),
    .din(rxdPin),
    .dout(rxSync)
  );

  assign wrCtrl = wrStrobe && (addr == CXL_REG_CTRL);
  assign clrStatus = wrStrobe && (addr == CXL_REG_STATUS);
  // Falling edge of receive is a dominant bus edge
  assign dominantEdge = rxPrev && !rxSync;

  // ---------------------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------------------
  // Hardware clears the standby bit on autowake so software sees the mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CXL_CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl <= wrData;
    end else if (mode == CXL_STANDBY && dominantEdge && ctrl[CXL_CTRL_AUTOWAKE]) begin
      ctrl[CXL_CTRL_STANDBY] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Mode machine
  // ---------------------------------------------------------------------------
  always_comb begin
    next_mode = mode;
    case (mode)
      CXL_ACTIVE: begin
        if (ctrl[CXL_CTRL_STANDBY]) begin
          next_mode = CXL_STANDBY;
        end
      end
      CXL_STANDBY: begin
        if (!ctrl[CXL_CTRL_STANDBY]) begin
          next_mode = CXL_WAKING;
        end else if (dominantEdge && ctrl[CXL_CTRL_AUTOWAKE]) begin
          next_mode = CXL_WAKING;
        end
      end
      CXL_WAKING: begin
        if (ctrl[CXL_CTRL_STANDBY] && !wrCtrl) begin
          next_mode = CXL_STANDBY;
        end else if (wakeCnt == 8'h00) begin
          next_mode = CXL_ACTIVE;
        end
      end
      default: next_mode = CXL_ACTIVE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= CXL_ACTIVE;
    end else begin
      mode <= next_mode;
    end
  end

  // Driver needs the wake time before transmit is trusted again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeCnt <= 8'h00;
    end else if (mode != CXL_WAKING) begin
      wakeCnt <= CXL_WAKE_CYC8 - 8'h01;
    end else if (wakeCnt != 8'h00) begin
      wakeCnt <= wakeCnt - 8'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // Activity flags (set wins over clear)
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxPrev <= 1'b1;
      activity <= 1'b0;
      woken <= 1'b0;
    end else begin
      rxPrev <= rxSync;
      if (dominantEdge) begin
        activity <= 1'b1;
      end else if (clrStatus && wrData[CXL_ST_ACTIVITY]) begin
        activity <= 1'b0;
      end
      if (mode == CXL_STANDBY && next_mode == CXL_WAKING && ctrl[CXL_CTRL_STANDBY]) begin
        woken <= 1'b1;
      end else if (clrStatus && wrData[CXL_ST_WOKEN]) begin
        woken <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------------------
  // Registered pins; transmit held recessive outside active mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins.modeSelect <= 1'b0;
      pins.loopbackSelect <= 1'b0;
      pins.txd <= 1'b1;
    end else begin
      pins.modeSelect <= (next_mode == CXL_STANDBY);
      // Software runs the baud trials through this bit
      pins.loopbackSelect <= ctrl[CXL_CTRL_LOOPBACK];
      if (next_mode == CXL_ACTIVE) begin
        pins.txd <= protoTxd & ctrl[CXL_CTRL_TXBIT] ? 1'b1 : protoTxd;
      end else begin
        pins.txd <= 1'b1;
      end
    end
  end

  // Receive passes straight on; the device merges the loopback path
  assign protoRxd = rxSync;

  // ---------------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 8'h00;
    end else if (rdStrobe) begin
      case (addr)
        CXL_REG_CTRL: rdData <= ctrl;
        CXL_REG_STATUS: rdData <= {3'b000, pins.loopbackSelect, mode == CXL_STANDBY,
                                   woken, activity, rxSync};
        CXL_REG_TXDATA: rdData <= {6'b000000, pins.txd, protoTxd};
        CXL_REG_WAKECNT: rdData <= wakeCnt;
        default: rdData <= 8'h00;
      endcase
    end else begin
      rdData <= 8'h00;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_standby_txd_idle: assert property (@(posedge clk) disable iff (!rst_n)
    pins.modeSelect |-> pins.txd) else $error("transmit not recessive in standby");
  a_standby_follows: assert property (@(posedge clk) disable iff (!rst_n)
    (wrCtrl && wrData[CXL_CTRL_STANDBY] && mode == CXL_ACTIVE) |=> ##1 pins.modeSelect)
    else $error("standby not entered");
  a_loop_follows: assert property (@(posedge clk) disable iff (!rst_n)
    wrCtrl |=> ##1 (pins.loopbackSelect == $past(wrData[CXL_CTRL_LOOPBACK], 2)))
    else $error("loopback pin wrong");
  a_wake_on_edge: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == CXL_STANDBY && dominantEdge && ctrl[CXL_CTRL_AUTOWAKE] && !wrCtrl)
    |=> ##[1:2] !pins.modeSelect) else $error("no wake on dominant edge");
  a_wake_time: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == CXL_STANDBY && next_mode == CXL_WAKING) |=> (mode == CXL_WAKING)[*8])
    else $error("wake time too short");
  a_active_txd: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == CXL_ACTIVE && next_mode == CXL_ACTIVE && !protoTxd) |=> !pins.txd)
    else $error("dominant not driven");
  a_rx_passes: assert property (@(posedge clk) disable iff (!rst_n)
    protoRxd == rxSync) else $error("receive path broken");
  a_activity_set: assert property (@(posedge clk) disable iff (!rst_n)
    dominantEdge |=> activity) else $error("activity not flagged");
endmodule
`default_nettype wire

// >>> bench/cxl_xcvr_model.sv
// Behavioural transceiver model facing the mode controller
`default_nettype none
module cxl_xcvr_model
  import cxl_pkg::*;
(
  input wire cxl_pins_t pins,
  input wire logic otherDom,
  output logic busDom,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lbk;
  logic drvOn;
  // ---------------------------------------------------------------------------
  // Mode decode and bus
  // ---------------------------------------------------------------------------
  // Floating or unknown loopback input reads as low, like a pull-down
  assign lbk = (pins.loopbackSelect === 1'b1);
  // Driver only in active mode without loopback; no slope resistor modelled
  assign drvOn = (pins.modeSelect === 1'b0) && !lbk;
  // Other nodes may pull dominant at any time
  assign busDom = otherDom || (drvOn && (pins.txd === 1'b0));
  // Receiver always alive; loopback folds local transmit in
  assign rxd = !busDom && !(lbk && (pins.txd === 1'b0));
endmodule
`default_nettype wire

// >>> bench/test_cxl_ctrl.sv
// Self-checking bench for the transceiver mode controller
`default_nettype none
module test_cxl_ctrl
  import cxl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wrData = 8'h00;
  logic wrStrobe = 1'b0;
  logic rdStrobe = 1'b0;
  logic protoTxd = 1'b1;
  logic otherDom = 1'b0;
  logic [7:0] rdData;
  logic protoRxd;
  logic rxd;
  logic busDom;
  cxl_pins_t pins;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  // Clock and parts
  always #5 clk = ~clk;
  cxl_ctrl dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .protoTxd(protoTxd),
    .protoRxd(protoRxd), .rxdPin(rxd), .pins(pins));
  cxl_xcvr_model xcvr_u (.pins(pins), .otherDom(otherDom), .busDom(busDom), .rxd(rxd));
  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Pins move two edges after the write; sync adds two more
  task automatic settle();
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
    settle();
  endtask
  task automatic read_reg(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] exp,
    input string what);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1;
    check(what, exp, rdData & mask);
  endtask
  task automatic drive(input logic t, input logic o);
    @(posedge clk);
    protoTxd <= t;
    otherDom <= o;
    settle();
  endtask
  // Hang guard: whole run needs well under 2000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    check("txd idle", 8'h01, pins.txd);
    check("mode active", 8'h00, pins.modeSelect);
    check("loopback off", 8'h00, pins.loopbackSelect);
    drive(1'b0, 1'b0);
    check("bus dominant", 8'h01, busDom);
    check("rx dominant", 8'h00, protoRxd);
    drive(1'b1, 1'b0);
    check("bus recessive", 8'h00, busDom);
    $display("Test active done");
    // Loopback: local bits stay off the bus but come back
    write_reg(CXL_REG_CTRL, 8'h02);
    check("loopback pin", 8'h01, pins.loopbackSelect);
    drive(1'b0, 1'b0);
    check("bus held", 8'h00, busDom);
    check("rx looped", 8'h00, protoRxd);
    drive(1'b1, 1'b1);
    check("rx from bus", 8'h00, protoRxd);
    drive(1'b1, 1'b0);
    check("rx recessive", 8'h01, protoRxd);
    read_reg(CXL_REG_STATUS, 8'h18, 8'h10, "status loopback");
    write_reg(CXL_REG_CTRL, 8'h00);
    drive(1'b0, 1'b0);
    check("bus restored", 8'h01, busDom);
    $display("Test loopback done");
    // Standby: driver off, receiver still listening
    drive(1'b1, 1'b0);
    write_reg(CXL_REG_CTRL, 8'h01);
    check("mode standby", 8'h01, pins.modeSelect);
    drive(1'b0, 1'b0);
    check("bus passive", 8'h00, busDom);
    drive(1'b1, 1'b1);
    check("rx standby", 8'h00, protoRxd);
    read_reg(CXL_REG_STATUS, 8'h19, 8'h08, "status standby");
    drive(1'b1, 1'b0);
    write_reg(CXL_REG_CTRL, 8'h00);
    check("mode woken", 8'h00, pins.modeSelect);
    repeat (160) @(posedge clk);
    drive(1'b0, 1'b0);
    check("bus after wake", 8'h01, busDom);
    $display("Test standby done");
    // Autowake: a dominant edge in standby wakes the driver and flags it
    drive(1'b1, 1'b0);
    write_reg(CXL_REG_CTRL, 8'h05);
    check("autowake standby", 8'h01, pins.modeSelect);
    drive(1'b1, 1'b1);
    check("autowake mode", 8'h00, pins.modeSelect);
    read_reg(CXL_REG_STATUS, 8'h06, 8'h06, "status woken");
    read_reg(CXL_REG_CTRL, 8'hff, 8'h04, "ctrl after wake");
    drive(1'b1, 1'b0);
    write_reg(CXL_REG_STATUS, 8'h06);
    read_reg(CXL_REG_STATUS, 8'h06, 8'h00, "status cleared");
    read_reg(CXL_REG_TXDATA, 8'h01, 8'h01, "txdata proto");
    repeat (160) @(posedge clk);
    $display("Test autowake done");
    read_reg(4'h7, 8'hff, 8'h00, "unmapped read");
    $display("Test unmapped done");
    report_and_stop();
  end
endmodule
`default_nettype wire
